//--- hw/adc_sequence_input_select.sv
// APB register and input routing for an eight-step sample sequencer
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
module adc_sequence_input_select #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  // Sequencer step
  input  wire logic                        step_valid,
  input  wire logic [2:0]                  step_index,
  // Converter input multiplexer
  output var  adc_step_sel_pkg::field_type input_select,
  output var  logic                        select_valid
);
  import adc_step_sel_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 8 and 32");
  end

  localparam logic [ADDR_W-1:0] SEL_ADDR  = ADDR_W'(SEL_OFFSET);
  localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'(STATUS_OFFSET);

  logic [31:0] sel_q;
  logic [31:0] sel_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  field_type   input_select_q;
  field_type   input_select_d;
  logic        select_valid_q;
  logic        select_valid_d;
  logic [2:0]  step_q;
  logic [2:0]  step_d;

  logic        setup;
  logic        access;
  logic        hit_sel;
  logic        hit_stat;
  logic [31:0] lane_mask;
  logic [31:0] wr_mask;
  logic [31:0] status_word;

  step_sel_if sel_bus ();

  step_field_decoder u_decoder (
    .sel (sel_bus.dec)
  );

  assign sel_bus.sel_word   = sel_q;
  assign sel_bus.step_index = step_index;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_sel  = paddr == SEL_ADDR;
  assign hit_stat = paddr == STAT_ADDR;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign lane_mask[b*8 +: 8] = {8{pstrb[b]}};
  end

  assign wr_mask = lane_mask & WRITE_MASK;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_ACTIVE_BIT] = select_valid_q;
    status_word[STAT_STEP_LSB +: 3] = step_q;
    status_word[STAT_INPUT_LSB +: FIELD_W] = input_select_q;
  end

  assign pready  = 1'b1;
  assign pslverr = access && !hit_sel && !hit_stat;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    sel_d    = sel_q;
    prdata_d = prdata_q;
    if (access && pwrite && hit_sel) begin
      sel_d = (sel_q & ~wr_mask) | (pwdata & wr_mask);
    end
    if (setup && !pwrite) begin
      if (hit_sel) begin
        prdata_d = sel_q & WRITE_MASK;
      end else if (hit_stat) begin
        prdata_d = status_word;
      end else begin
        prdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q    <= SEL_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      sel_q    <= sel_d;
      prdata_q <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Input routing to the multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    input_select_d = input_select_q;
    select_valid_d = step_valid;
    step_d         = step_q;
    if (step_valid) begin
      input_select_d = sel_bus.field;
      step_d         = step_index;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_q <= '0;
      select_valid_q <= 1'b0;
      step_q         <= 3'h0;
    end else begin
      input_select_q <= input_select_d;
      select_valid_q <= select_valid_d;
      step_q         <= step_d;
    end
  end

  assign input_select = input_select_q;
  assign select_valid = select_valid_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  step1_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h0 |=>
      input_select_q == step_field($past(sel_q), 3'h0) && select_valid_q)
    else $error("step one routed the wrong input");

  step2_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h1 |=>
      input_select_q == $past(sel_q[6:4]))
    else $error("step two routed the wrong input");

  step3_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h2 |=>
      input_select_q == $past(sel_q[10:8]))
    else $error("step three routed the wrong input");

  step4_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h3 |=>
      input_select_q == $past(sel_q[14:12]))
    else $error("step four routed the wrong input");

  step5_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h4 |=>
      input_select_q == $past(sel_q[18:16]))
    else $error("step five routed the wrong input");

  step6_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h5 |=>
      input_select_q == $past(sel_q[22:20]))
    else $error("step six routed the wrong input");

  step7_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h6 |=>
      input_select_q == $past(sel_q[26:24]))
    else $error("step seven routed the wrong input");

  step8_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h7 |=>
      input_select_q == $past(sel_q[30:28]))
    else $error("step eight routed the wrong input");

  fields_reset_a: assert property (@(posedge pclk)
    !presetn |-> sel_q == SEL_RESET && input_select_q == '0)
    else $error("selection fields not zero in reset");

  reserved_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_q & ~WRITE_MASK) == 32'h0000_0000)
    else $error("reserved bit stored a value");

  reserved_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && hit_sel |=>
      prdata_q == $past(sel_q) && (prdata_q & ~WRITE_MASK) == 32'h0)
    else $error("read data of selection register wrong");

  write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && hit_sel && pstrb == 4'hF |=>
      sel_q == ($past(pwdata) & WRITE_MASK))
    else $error("full write did not land masked");

  hold_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !step_valid |=> $stable(input_select_q) && !select_valid_q)
    else $error("input select moved outside a step");

  step1_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h0);
  step8_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    step_valid && step_index == 3'h7 ##1 step_valid && step_index == 3'h0);
  write_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && hit_sel);
  error_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    pslverr);

endmodule
`default_nettype wire

//--- hw/adc_step_sel_pkg.sv
// Constants and helpers for the sequence step input selection block
`default_nettype none
package adc_step_sel_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] SEL_OFFSET    = 12'h040;
  localparam logic [11:0] STATUS_OFFSET = 12'h04C;

  // ----------------------------------------------------------------
  // Field layout of the selection register
  // ----------------------------------------------------------------
  localparam int          NUM_STEPS    = 8;
  localparam int          FIELD_W      = 3;
  localparam int          FIELD_STRIDE = 4;
  localparam logic [31:0] WRITE_MASK   = 32'h7777_7777;
  localparam logic [31:0] SEL_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field layout of the status register
  // ----------------------------------------------------------------
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_STEP_LSB   = 4;
  localparam int STAT_INPUT_LSB  = 8;

  typedef logic [FIELD_W-1:0] field_type;

  // Picks the input number of one step out of the selection word
  function automatic field_type step_field(input logic [31:0] word,
                                           input logic [2:0]  step);
    step_field = word[step*FIELD_STRIDE +: FIELD_W];
  endfunction

endpackage
`default_nettype wire

//--- hw/step_sel_if.sv
// Bundle between the register side and the step decoder
`default_nettype none
interface step_sel_if;
  logic [31:0] sel_word;
  logic [2:0]  step_index;
  logic [2:0]  field;

  modport regs (output sel_word, output step_index, input field);
  modport dec  (input sel_word, input step_index, output field);
endinterface
`default_nettype wire

//--- hw/step_field_decoder.sv
// Step decoder: selects the input number field of the running step
`default_nettype none
module step_field_decoder (
  step_sel_if.dec sel
);
  import adc_step_sel_pkg::*;

  logic [FIELD_W-1:0] fields [NUM_STEPS];

  // ----------------------------------------------------------------
  // One field per step, stride of four bits
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_STEPS; i++) begin : g_field
    assign fields[i] = sel.sel_word[i*FIELD_STRIDE +: FIELD_W];
  end

  assign sel.field = fields[sel.step_index];
endmodule
`default_nettype wire

//--- verification/analog_mux_model.sv
// Model of the converter input multiplexer fed by the selection block
`default_nettype none
module analog_mux_model
  import adc_step_sel_pkg::*;
(
  // Clock and reset
  input  wire logic      pclk,
  input  wire logic      presetn,
  // Selection from the block
  input  wire field_type input_select,
  input  wire logic      select_valid,
  // Input that is connected to the converter
  output var  field_type routed
);
  timeunit 1ns;
  timeprecision 1ps;

  // Switches only on a valid selection, so a stale number stays visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      routed <= '0;
    end else if (select_valid) begin
      routed <= input_select;
    end
  end
endmodule
`default_nettype wire

//--- verification/adc_sequence_input_select_tb.sv
// Testbench for the sequence step input selection block
`default_nettype none
module adc_sequence_input_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_step_sel_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk = 0, presetn = 1, psel = 0, penable = 0;
  logic        pwrite = 0, step_valid = 0, pready, pslverr, err;
  logic        select_valid;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [2:0]  step_index = '0;
  field_type   input_select, routed;
  int          bad_count = 0, samples_checked = 0;

  always #25 pclk = ~pclk;

  adc_sequence_input_select u_adc_sequence_input_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_valid(step_valid), .step_index(step_index),
    .input_select(input_select), .select_valid(select_valid));

  analog_mux_model u_analog_mux_model (
    .pclk(pclk), .presetn(presetn), .input_select(input_select),
    .select_valid(select_valid), .routed(routed));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask

  // Runs one step and follows the number to the multiplexer
  task automatic step(input logic [2:0] idx, input field_type exp);
    @(posedge pclk);
    step_valid <= 1;
    step_index <= idx;
    @(posedge pclk);
    step_valid <= 0;
    @(negedge pclk);
    check("valid", 32'(select_valid), 32'h1);
    check("select", 32'(input_select), 32'(exp));
    @(posedge pclk);
    @(negedge pclk);
    check("routed", 32'(routed), 32'(exp));
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    // Falling edge at time zero resets the flops before the first clock
    presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, SEL_OFFSET, 32'h0, rd, err);
    check("reset", rd, 32'h0000_0000);
    apb(1, SEL_OFFSET, 32'hFFFF_FFFF, rd, err);
    apb(0, SEL_OFFSET, 32'h0, rd, err);
    check("reserved", rd, 32'h7777_7777);
    apb(1, SEL_OFFSET, 32'h7654_3210, rd, err);
    for (int i = 0; i < 8; i++) step(3'(i), 3'(i));
    apb(1, SEL_OFFSET, 32'h0123_4567, rd, err);
    for (int i = 0; i < 8; i++) step(3'(i), 3'(7 - i));
    // Read-modify-write of the third step field only
    apb(0, SEL_OFFSET, 32'h0, rd, err);
    rd = (rd & ~32'h0000_0700) | 32'h0000_0200;
    apb(1, SEL_OFFSET, rd, rd, err);
    apb(0, SEL_OFFSET, 32'h0, rd, err);
    check("rmw", rd, 32'h0123_4267);
    check("okay", 32'(err), 32'h0);
    step(3'h2, 3'h2);
    // Status ignores writes and reports the last step and its input
    apb(1, STATUS_OFFSET, 32'hFFFF_FFFF, rd, err);
    check("status write err", 32'(err), 32'h0);
    apb(0, STATUS_OFFSET, 32'h0, rd, err);
    check("status", rd,
          (32'h2 << STAT_INPUT_LSB) | (32'h2 << STAT_STEP_LSB));
    apb(0, 12'h100, 32'h0, rd, err);
    check("unmapped data", rd, 32'h0000_0000);
    check("unmapped err", 32'(err), 32'h1);
    // Reset in mid-run brings every field back to zero
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, SEL_OFFSET, 32'h0, rd, err);
    check("rerun reset", rd, SEL_RESET);
    step(3'h6, 3'h0);
    end_of_test();
  end

  initial begin
    #(50 * 5000);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
